/* ipc_regs.v */
// Notes on behaviour
// - Four channel enable bits, cleared at reset
// - Read-only per-channel active status, reset zero
// - Bit 10 selects per-channel or global rate
// - Path 1 bit 0 selects analog or digital
// - Analog oversample 010 mid-power, 101 normal
// - Digital oversample code picks density clock
// - Code 110 gives high-performance density mode
// - Bits 9:8 pick level reference rail
// - Path 1 source field picks pin pair
// - Per-channel highpass enable
// - Path 1 low-power bit, analog only
// - Seven-bit gain, 0x40 is 0 dB
// - Mid-power lifts gain to at least 6 dB
// - Slow system clock refuses new enables only
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_regs (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // Host control port
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [15:0] host_addr,
  input  wire [31:0] host_wdata,
  output reg  [31:0] host_rdata,
  // System clock check
  input  wire        system_clock_ok,
  // Channel control
  output reg  [3:0]  channel_run,
  output reg         per_channel_rate,
  output reg         path1_digital_select,
  output reg  [2:0]  path1_oversample_code,
  output reg  [2:0]  path2_oversample_code,
  output reg  [1:0]  path1_level_reference,
  output reg  [1:0]  path2_level_reference,
  output reg         path1_mid_power,
  output reg         path1_density_hiperf,
  output reg         path2_density_hiperf,
  output reg  [1:0]  path1_left_pin_source,
  output reg  [1:0]  path1_right_pin_source,
  output reg  [3:0]  highpass_on,
  output reg         path1_left_low_power,
  output reg         path1_right_low_power,
  output reg  [6:0]  path1_left_analog_gain,
  output reg  [6:0]  path1_right_analog_gain
);

  ////////////////////////////////////////////////////////////////////////////
  // Stored fields

  reg  [3:0]  enable_r;
  reg         rate_mode_r;
  reg  [2:0]  osr1_r;
  reg  [2:0]  osr2_r;
  reg  [1:0]  ref1_r;
  reg  [1:0]  ref2_r;
  reg         keep1_r;
  reg         keep2_r;
  reg         dig1_r;
  reg  [1:0]  src_l_r;
  reg  [1:0]  src_r_r;
  reg  [3:0]  hpf_r;
  reg         lp_l_r;
  reg         lp_r_r;
  reg  [6:0]  gain_l_r;
  reg  [6:0]  gain_r_r;
  wire [3:0]  active;
  wire [6:0]  gain_l_eff;
  wire [6:0]  gain_r_eff;
  reg  [31:0] rd_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Shared decodes

  // Code 110 is the fast density clock on either path
  function hiperf_sel;
    input [2:0] osr;
    begin
      hiperf_sel = (osr == `IPC_OSR_HIPERF);
    end
  endfunction

  // Mid-power only exists on the analog input
  function mid_power_sel;
    input       digital;
    input [2:0] osr;
    begin
      mid_power_sel = !digital && (osr == `IPC_OSR_MID);
    end
  endfunction

  // Low power has no meaning on a digital input
  function low_power_sel;
    input lp;
    input digital;
    begin
      low_power_sel = lp && !digital;
    end
  endfunction

  function [31:0] src_word;
    input [1:0] src;
    input       hpf;
    input       lp;
    begin
      src_word                              = 32'h0;
      src_word[`IPC_B_SRC_HI:`IPC_B_SRC_LO] = src;
      src_word[`IPC_B_HPF]                  = hpf;
      src_word[`IPC_B_LOWPWR]               = lp;
    end
  endfunction

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      enable_r    <= 4'h0;
      rate_mode_r <= `IPC_RST_RATE_MODE;
      osr1_r      <= `IPC_RST_OSR;
      osr2_r      <= `IPC_RST_OSR;
      ref1_r      <= `IPC_RST_REF;
      ref2_r      <= `IPC_RST_REF;
      keep1_r     <= 1'b0;
      keep2_r     <= 1'b0;
      dig1_r      <= 1'b0;
      src_l_r     <= `IPC_RST_SRC;
      src_r_r     <= `IPC_RST_SRC;
      hpf_r       <= 4'h0;
      lp_l_r      <= 1'b0;
      lp_r_r      <= 1'b0;
      gain_l_r    <= `IPC_RST_GAIN;
      gain_r_r    <= `IPC_RST_GAIN;
    end else if (host_wr) begin
      // Reserved codes kept verbatim
      case (host_addr)
        `IPC_A_ENABLE: begin
          enable_r <= host_wdata[3:0];
        end
        `IPC_A_RATE: begin
          rate_mode_r <= host_wdata[`IPC_B_RATE_MODE];
        end
        `IPC_A_P1_MODE: begin
          osr1_r  <= host_wdata[`IPC_B_OSR_HI:`IPC_B_OSR_LO];
          ref1_r  <= host_wdata[`IPC_B_REF_HI:`IPC_B_REF_LO];
          keep1_r <= host_wdata[`IPC_B_KEEP];
          dig1_r  <= host_wdata[`IPC_B_DIGITAL];
        end
        `IPC_A_P1L_SRC: begin
          src_l_r  <= host_wdata[`IPC_B_SRC_HI:`IPC_B_SRC_LO];
          hpf_r[1] <= host_wdata[`IPC_B_HPF];
          lp_l_r   <= host_wdata[`IPC_B_LOWPWR];
        end
        `IPC_A_P1L_GAIN: begin
          gain_l_r <= host_wdata[`IPC_B_GAIN_HI:`IPC_B_GAIN_LO];
        end
        `IPC_A_P1R_SRC: begin
          src_r_r  <= host_wdata[`IPC_B_SRC_HI:`IPC_B_SRC_LO];
          hpf_r[0] <= host_wdata[`IPC_B_HPF];
          lp_r_r   <= host_wdata[`IPC_B_LOWPWR];
        end
        `IPC_A_P1R_GAIN: begin
          gain_r_r <= host_wdata[`IPC_B_GAIN_HI:`IPC_B_GAIN_LO];
        end
        `IPC_A_P2_CLK: begin
          osr2_r  <= host_wdata[`IPC_B_OSR_HI:`IPC_B_OSR_LO];
          ref2_r  <= host_wdata[`IPC_B_REF_HI:`IPC_B_REF_LO];
          keep2_r <= host_wdata[`IPC_B_KEEP];
        end
        `IPC_A_P2L_FILT: begin
          hpf_r[3] <= host_wdata[`IPC_B_HPF];
        end
        `IPC_A_P2R_FILT: begin
          hpf_r[2] <= host_wdata[`IPC_B_HPF];
        end
        default: begin
          enable_r <= enable_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable acceptance, one gate per channel

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gate
      ipc_chan_gate u_gate (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .enable_req (enable_r[g]),
        .clock_ok   (system_clock_ok),
        .active     (active[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Applied gain

  ipc_gain_eff u_gain_l (
    .gain_code    (gain_l_r),
    .osr_code     (osr1_r),
    .digital_sel  (dig1_r),
    .gain_applied (gain_l_eff)
  );

  ipc_gain_eff u_gain_r (
    .gain_code    (gain_r_r),
    .osr_code     (osr1_r),
    .digital_sel  (dig1_r),
    .gain_applied (gain_r_eff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Readback; unmapped addresses read zero

  always @* begin
    rd_nxt = 32'h0;
    case (host_addr)
      `IPC_A_ENABLE:   rd_nxt[3:0] = enable_r;
      `IPC_A_STATUS:   rd_nxt[3:0] = active;
      `IPC_A_RATE:     rd_nxt[`IPC_B_RATE_MODE] = rate_mode_r;
      `IPC_A_P1_MODE: begin
        rd_nxt[`IPC_B_OSR_HI:`IPC_B_OSR_LO] = osr1_r;
        rd_nxt[`IPC_B_REF_HI:`IPC_B_REF_LO] = ref1_r;
        rd_nxt[`IPC_B_KEEP]                 = keep1_r;
        rd_nxt[`IPC_B_DIGITAL]              = dig1_r;
      end
      `IPC_A_P1L_SRC:  rd_nxt = src_word(src_l_r, hpf_r[1], lp_l_r);
      `IPC_A_P1L_GAIN: rd_nxt[`IPC_B_GAIN_HI:`IPC_B_GAIN_LO] = gain_l_r;
      `IPC_A_P1R_SRC:  rd_nxt = src_word(src_r_r, hpf_r[0], lp_r_r);
      `IPC_A_P1R_GAIN: rd_nxt[`IPC_B_GAIN_HI:`IPC_B_GAIN_LO] = gain_r_r;
      `IPC_A_P2_CLK: begin
        rd_nxt[`IPC_B_OSR_HI:`IPC_B_OSR_LO] = osr2_r;
        rd_nxt[`IPC_B_REF_HI:`IPC_B_REF_LO] = ref2_r;
        rd_nxt[`IPC_B_KEEP]                 = keep2_r;
      end
      `IPC_A_P2L_FILT: rd_nxt[`IPC_B_HPF] = hpf_r[3];
      `IPC_A_P2R_FILT: rd_nxt[`IPC_B_HPF] = hpf_r[2];
      default:         rd_nxt = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, one cycle behind the stored fields

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata              <= 32'h0;
      channel_run             <= 4'h0;
      per_channel_rate        <= `IPC_RST_RATE_MODE;
      path1_digital_select    <= 1'b0;
      path1_oversample_code   <= `IPC_RST_OSR;
      path2_oversample_code   <= `IPC_RST_OSR;
      path1_level_reference   <= `IPC_RST_REF;
      path2_level_reference   <= `IPC_RST_REF;
      path1_mid_power         <= 1'b0;
      path1_density_hiperf    <= 1'b0;
      path2_density_hiperf    <= 1'b0;
      path1_left_pin_source   <= `IPC_RST_SRC;
      path1_right_pin_source  <= `IPC_RST_SRC;
      highpass_on             <= 4'h0;
      path1_left_low_power    <= 1'b0;
      path1_right_low_power   <= 1'b0;
      path1_left_analog_gain  <= `IPC_RST_GAIN;
      path1_right_analog_gain <= `IPC_RST_GAIN;
    end else begin
      if (host_rd) begin
        host_rdata <= rd_nxt;
      end
      channel_run             <= active;
      per_channel_rate        <= rate_mode_r;
      path1_digital_select    <= dig1_r;
      path1_oversample_code   <= osr1_r;
      path2_oversample_code   <= osr2_r;
      path1_level_reference   <= ref1_r;
      path2_level_reference   <= ref2_r;
      path1_mid_power         <= mid_power_sel(dig1_r, osr1_r);
      path1_density_hiperf    <= dig1_r && hiperf_sel(osr1_r);
      path2_density_hiperf    <= hiperf_sel(osr2_r);
      path1_left_pin_source   <= src_l_r;
      path1_right_pin_source  <= src_r_r;
      highpass_on             <= hpf_r;
      path1_left_low_power    <= low_power_sel(lp_l_r, dig1_r);
      path1_right_low_power   <= low_power_sel(lp_r_r, dig1_r);
      path1_left_analog_gain  <= gain_l_eff;
      path1_right_analog_gain <= gain_r_eff;
    end
  end

endmodule
`default_nettype wire

/* ipc_consts.vh */
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH

// Register addresses, byte offsets on the host control port
`define IPC_A_ENABLE      16'h4000
`define IPC_A_STATUS      16'h4004
`define IPC_A_RATE        16'h4008
`define IPC_A_P1_MODE     16'h4020
`define IPC_A_P1L_SRC     16'h4024
`define IPC_A_P1L_GAIN    16'h4028
`define IPC_A_P1R_SRC     16'h4044
`define IPC_A_P1R_GAIN    16'h4048
`define IPC_A_P2_CLK      16'h4060
`define IPC_A_P2L_FILT    16'h4064
`define IPC_A_P2R_FILT    16'h4084

// Field positions
`define IPC_B_RATE_MODE   10
`define IPC_B_OSR_HI      18
`define IPC_B_OSR_LO      16
`define IPC_B_REF_HI      9
`define IPC_B_REF_LO      8
`define IPC_B_KEEP        5
`define IPC_B_DIGITAL     0
`define IPC_B_SRC_HI      29
`define IPC_B_SRC_LO      28
`define IPC_B_HPF         2
`define IPC_B_LOWPWR      0
`define IPC_B_GAIN_HI     7
`define IPC_B_GAIN_LO     1

// Reset values
`define IPC_RST_RATE_MODE 1'b1
`define IPC_RST_OSR       3'h5
`define IPC_RST_REF       2'h0
`define IPC_RST_SRC       2'h0
`define IPC_RST_GAIN      7'h40

// Codes
`define IPC_OSR_MID       3'h2
`define IPC_OSR_NORMAL    3'h5
`define IPC_OSR_HIPERF    3'h6
`define IPC_GAIN_MIN_MID  7'h46

// Enable acceptance settle, in ns and in cycles of the 100 MHz clock
`define IPC_CLK_NS        10
`define IPC_ACCEPT_NS     40
`define IPC_ACCEPT_CYC    ((`IPC_ACCEPT_NS + `IPC_CLK_NS - 1) / `IPC_CLK_NS)

`endif

/* ipc_gain_eff.v */
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_gain_eff (
  // Programmed setting
  input  wire [6:0] gain_code,
  input  wire [2:0] osr_code,
  input  wire       digital_sel,
  // Gain as applied to the amplifier
  output wire [6:0] gain_applied
);

  wire mid_power;

  assign mid_power = !digital_sel && (osr_code == `IPC_OSR_MID);
  // Floor at 6 dB; reserved codes below 0x40 are lifted too
  assign gain_applied = (mid_power && gain_code < `IPC_GAIN_MIN_MID) ? `IPC_GAIN_MIN_MID : gain_code;

endmodule
`default_nettype wire

/* ipc_chan_gate.v */
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_chan_gate (
  // Clock and reset
  input  wire ref_clk,
  input  wire nrst,
  // Request and clock check
  input  wire enable_req,
  input  wire clock_ok,
  // Result
  output reg  active
);

  localparam integer accept_last = `IPC_ACCEPT_CYC - 1;

  reg [2:0] settle_r;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active   <= 1'b0;
      settle_r <= 3'h0;
    end else if (!enable_req) begin
      active   <= 1'b0;
      settle_r <= 3'h0;
    end else if (!active) begin
      // Running channels are left alone when the clock check drops
      if (!clock_ok) begin
        settle_r <= 3'h0;
      end else if ({29'h0, settle_r} == accept_last) begin
        active <= 1'b1;
      end else begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* ipc_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.vh"
module ipc_regs_sva (
  // Clock, reset and host port
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        host_wr,
  input wire logic        host_rd,
  input wire logic [15:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  // Watched controls
  input wire logic        system_clock_ok,
  input wire logic [3:0]  channel_run,
  input wire logic        path1_digital_select,
  input wire logic [2:0]  path1_oversample_code,
  input wire logic [2:0]  path2_oversample_code,
  input wire logic        path1_mid_power,
  input wire logic        path1_density_hiperf,
  input wire logic        path2_density_hiperf,
  input wire logic        path1_left_low_power,
  input wire logic [6:0]  path1_left_analog_gain
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  sequence set_p1l;
    host_wr && host_addr == `IPC_A_ENABLE && host_wdata[1] && !channel_run[1];
  endsequence
  // Quiet window leaves the gate time to settle
  sequence quiet_ok;
    (system_clock_ok && !host_wr) [*7];
  endsequence
  accept_run_a: assert property (set_p1l ##1 quiet_ok |-> channel_run[1])
    else $error("enable not accepted");
  refuse_run_a: assert property ($rose(channel_run[0]) |-> $past(system_clock_ok, 2) && $past(system_clock_ok, 3))
    else $error("enable accepted without clock");
  clear_run_a: assert property (host_wr && host_addr == `IPC_A_ENABLE && !host_wdata[1] |-> ##[1:3] !channel_run[1])
    else $error("status not cleared");
  mid_power_a: assert property (path1_mid_power == (!path1_digital_select && path1_oversample_code == `IPC_OSR_MID))
    else $error("mid power mismatch");
  p1_hiperf_a: assert property (path1_density_hiperf == (path1_digital_select && path1_oversample_code == `IPC_OSR_HIPERF))
    else $error("path1 hiperf mismatch");
  p2_hiperf_a: assert property (path2_density_hiperf == (path2_oversample_code == `IPC_OSR_HIPERF))
    else $error("path2 hiperf mismatch");
  gain_floor_a: assert property (path1_mid_power |-> path1_left_analog_gain >= `IPC_GAIN_MIN_MID)
    else $error("gain below floor");
  low_power_a: assert property (path1_digital_select |-> !path1_left_low_power)
    else $error("low power in digital");
  hold_rdata_a: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved");
  unmapped_rd_a: assert property (host_rd && host_addr == 16'h4010 |=> host_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* test_ipc_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ipc_consts.vh"
module test_ipc_regs;
  logic        ref_clk = 0, nrst = 0, host_wr = 0, host_rd = 0, system_clock_ok = 0;
  logic [15:0] host_addr = 0;
  logic [31:0] host_wdata = 0, host_rdata;
  logic [3:0]  channel_run, highpass_on;
  logic        per_channel_rate, path1_digital_select, path1_mid_power, path1_density_hiperf;
  logic        path2_density_hiperf, path1_left_low_power, path1_right_low_power;
  logic [2:0]  path1_oversample_code, path2_oversample_code;
  logic [1:0]  path1_level_reference, path2_level_reference, path1_left_pin_source, path1_right_pin_source;
  logic [6:0]  path1_left_analog_gain, path1_right_analog_gain;
  int          n_errors = 0, n_compared = 0, cyc = 0;
  // Address, reset value, writable mask
  logic [15:0] adr [0:11] = '{16'h4000, 16'h4004, 16'h4008, 16'h4020, 16'h4024, 16'h4028,
                              16'h4044, 16'h4048, 16'h4060, 16'h4064, 16'h4084, 16'h4010};
  logic [31:0] rst [0:11] = '{32'h0, 32'h0, 32'h400, 32'h50000, 32'h0, 32'h80,
                              32'h0, 32'h80, 32'h50000, 32'h0, 32'h0, 32'h0};
  logic [31:0] msk [0:11] = '{32'hf, 32'h0, 32'h400, 32'h70321, 32'h30000005, 32'hfe,
                              32'h30000005, 32'hfe, 32'h70320, 32'h4, 32'h4, 32'h0};
  ipc_regs dut_u (.ref_clk, .nrst, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
    .system_clock_ok, .channel_run, .per_channel_rate, .path1_digital_select, .path1_oversample_code,
    .path2_oversample_code, .path1_level_reference, .path2_level_reference, .path1_mid_power,
    .path1_density_hiperf, .path2_density_hiperf, .path1_left_pin_source, .path1_right_pin_source,
    .highpass_on, .path1_left_low_power, .path1_right_low_power, .path1_left_analog_gain,
    .path1_right_analog_gain);
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Ceiling well above the roughly 190 cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    #1 host_wr = 1;
    host_addr = a;
    host_wdata = d;
    @(posedge ref_clk);
    #1 host_wr = 0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    #1 host_rd = 1;
    host_addr = a;
    @(posedge ref_clk);
    #1 host_rd = 0;
    chk(host_rdata, e);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int i;
    repeat (16) @(posedge ref_clk);
    #1 nrst = 1;
    for (i = 0; i < 12; i++) rd(adr[i], rst[i]);
    // Clock too slow: every enable written now is refused
    for (i = 11; i >= 0; i--) wr(adr[i], 32'hffffffff);
    for (i = 0; i < 12; i++) rd(adr[i], msk[i]);
    chk({27'h0, path1_oversample_code, path1_level_reference}, 32'h1f);
    chk({29'h0, path1_right_pin_source, path1_right_low_power}, 32'h6);
    system_clock_ok = 1;
    repeat (8) @(posedge ref_clk);
    rd(`IPC_A_STATUS, 32'hf);
    system_clock_ok = 0;
    rd(`IPC_A_STATUS, 32'hf);
    chk({28'h0, channel_run}, 32'hf);
    chk({28'h0, highpass_on}, 32'hf);
    wr(`IPC_A_ENABLE, 32'h0);
    rd(`IPC_A_STATUS, 32'h0);
    wr(`IPC_A_P1L_SRC, 32'h30000004);
    wr(`IPC_A_P1R_SRC, 32'h20000000);
    wr(`IPC_A_P1_MODE, 32'h20020);
    wr(`IPC_A_P1L_GAIN, 32'h84);
    wr(`IPC_A_P1R_GAIN, 32'h80);
    chk({18'h0, path1_left_analog_gain, path1_right_analog_gain}, 32'h2346);
    chk({31'h0, path1_mid_power}, 32'h1);
    chk({28'h0, path1_left_pin_source, path1_right_pin_source}, 32'he);
    rd(`IPC_A_P1L_GAIN, 32'h84);
    wr(`IPC_A_P1_MODE, 32'h50020);
    chk({18'h0, path1_left_analog_gain, path1_right_analog_gain}, 32'h2140);
    chk({31'h0, path1_mid_power}, 32'h0);
    wr(`IPC_A_P1L_SRC, 32'h1);
    wr(`IPC_A_P1R_SRC, 32'h20000001);
    chk({30'h0, path1_left_low_power, path1_right_low_power}, 32'h3);
    wr(`IPC_A_P1_MODE, 32'h60021);
    chk({31'h0, path1_digital_select}, 32'h1);
    chk({31'h0, path1_density_hiperf}, 32'h1);
    chk({27'h0, path1_oversample_code, path1_level_reference}, 32'h18);
    chk({30'h0, path1_left_low_power, path1_right_low_power}, 32'h0);
    wr(`IPC_A_P2_CLK, 32'h60020);
    chk({31'h0, path2_density_hiperf}, 32'h1);
    wr(`IPC_A_P2_CLK, 32'h30120);
    chk({27'h0, path2_oversample_code, path2_level_reference}, 32'hd);
    chk({31'h0, path2_density_hiperf}, 32'h0);
    wr(`IPC_A_RATE, 32'h0);
    chk({31'h0, per_channel_rate}, 32'h0);
    system_clock_ok = 1;
    wr(`IPC_A_ENABLE, 32'h2);
    repeat (`IPC_ACCEPT_CYC - 2) @(posedge ref_clk);
    #1 chk({28'h0, channel_run}, 32'h0);
    @(posedge ref_clk);
    #1 chk({28'h0, channel_run}, 32'h2);
    rd(`IPC_A_STATUS, 32'h2);
    close_out();
  end
endmodule
bind ipc_regs ipc_regs_sva chk_u (.ref_clk, .nrst, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
  .system_clock_ok, .channel_run, .path1_digital_select, .path1_oversample_code, .path2_oversample_code,
  .path1_mid_power, .path1_density_hiperf, .path2_density_hiperf, .path1_left_low_power,
  .path1_left_analog_gain);
`default_nettype wire
